/* File: hw/tfci_pkg.sv */
// Purpose: Shared constants, state encodings and carriers of the indicator encoder.
// Assumes: One clock domain; all configuration arrives as plain ports.
// Notes: Code vectors hold chip 0 in their most significant bit, as chips are sent.

package tfci_pkg;

  localparam int INFO_BITS = 10;
  localparam int RM_LEN = 32;
  localparam int CODE_LEN = 30;
  localparam int SPLIT_BITS = 5;
  localparam int BIO_LEN = 16;
  localparam int SPLIT_LEN = 15;
  localparam int OVSF_BASES = 5;
  localparam int SPLIT_WORDS = 2;

  // Chip 0 sits in bit 31 and chip 16 in bit 15; both are punctured.
  localparam int RM_DROP_FIRST = 31;
  localparam int RM_DROP_SECOND = 15;
  // Chip 0 of a length-16 code sits in bit 15 and is punctured.
  localparam int BIO_DROP = 15;

  // Basis weights of the information bits.
  localparam int ALL_ONES_BIT = 5;
  localparam int FIRST_MASK_BIT = 6;

  // The first mask is printed with one chip too many; the surplus one in its
  // run of seven ones is dropped, leaving a run of six and 32 chips in all.
  localparam logic [31:0] FIRST_MASK_SEQUENCE = 32'h2863f077;
  localparam logic [31:0] SECOND_MASK_SEQUENCE = 32'h01cd6dc7;
  localparam logic [31:0] THIRD_MASK_SEQUENCE = 32'h0af91b2b;
  localparam logic [31:0] FOURTH_MASK_SEQUENCE = 32'h1c372f51;

  localparam logic [9:0] SF_REP_LIMIT = 10'h080;
  localparam logic [3:0] LAST_SLOT = 4'he;
  localparam logic [1:0] LAST_REP = 2'h3;
  localparam logic [4:0] TOP_BIT_IDX = 5'h1d;
  localparam logic [3:0] SPLIT_TOP_IDX = 4'he;
  localparam logic [6:0] FRAME_BITS_PLAIN = 7'h1e;
  localparam logic [6:0] FRAME_BITS_REP = 7'h78;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_SEND = 3'b100
  } enc_state_t;

  typedef struct packed {
    logic split_mode;
    logic downlink;
    logic [9:0] spreading_factor;
    logic [3:0] indicator_len;
  } tfci_cfg_t;

  typedef struct packed {
    logic code_bit;
    logic [3:0] slot;
    logic last;
  } tfci_sym_t;

  typedef struct packed {
    enc_state_t state;
    logic [9:0] info;
    logic [4:0] word_a;
    logic [4:0] word_b;
    logic split;
    logic rep;
    logic [3:0] slot;
    logic half;
    logic [1:0] rep_cnt;
    logic out_bit;
  } enc_regs_t;

  localparam enc_regs_t ENC_RESET = '{state: ST_IDLE, default: '0};

endpackage

/* File: hw/tfci_code_core.sv */
// Purpose: Combinational (32,10) sub-code and (16,5) biorthogonal encoders with puncturing.
// Assumes: Inputs come from registers; clk and rst_n serve only the checks.
// Notes: Hadamard rows are built from index parity, so no code table is stored.

`timescale 1ns/1ps
`default_nettype none

module tfci_code_core
  import tfci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [9:0] info,
  input wire logic [4:0] word_a,
  input wire logic [4:0] word_b,
  output logic [29:0] plain_code,
  output logic [14:0] split_code_a,
  output logic [14:0] split_code_b
);

  // Sylvester Hadamard row in binary form: chip j is the parity of idx AND j.
  function automatic logic [31:0] walsh32(input logic [4:0] idx);
    logic [31:0] w;
    w = '0;
    for (int j = 0; j < RM_LEN; j++) begin
      w[RM_LEN-1-j] = ^(idx & 5'(j));
    end
    return w;
  endfunction

  function automatic logic [15:0] bio16(input logic [4:0] w);
    logic [31:0] row;
    row = walsh32({1'b0, w[4:1]});
    return row[31:16] ^ {BIO_LEN{w[0]}};
  endfunction

  logic [31:0] rm_word;
  logic [31:0] masks [4];
  logic [15:0] bio_a;
  logic [15:0] bio_b;

  assign masks[0] = FIRST_MASK_SEQUENCE;
  assign masks[1] = SECOND_MASK_SEQUENCE;
  assign masks[2] = THIRD_MASK_SEQUENCE;
  assign masks[3] = FOURTH_MASK_SEQUENCE;

  always_comb begin
    rm_word = '0;
    for (int k = 0; k < OVSF_BASES; k++) begin
      if (info[k]) begin
        rm_word = rm_word ^ walsh32(5'(1 << k));
      end
    end
    if (info[ALL_ONES_BIT]) begin
      rm_word = ~rm_word;
    end
    for (int m = 0; m < 4; m++) begin
      if (info[FIRST_MASK_BIT+m]) begin
        rm_word = rm_word ^ masks[m];
      end
    end
  end

  // Deleting the first and seventeenth chips leaves b29 as the old chip 1.
  assign plain_code = {rm_word[RM_DROP_FIRST-1:RM_DROP_SECOND+1],
                       rm_word[RM_DROP_SECOND-1:0]};

  assign bio_a = bio16(word_a);
  assign bio_b = bio16(word_b);
  assign split_code_a = bio_a[BIO_DROP-1:0];
  assign split_code_b = bio_b[BIO_DROP-1:0];

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  first_mask_a: assert property ((info == 10'h040) |->
      (plain_code == {FIRST_MASK_SEQUENCE[30:16], FIRST_MASK_SEQUENCE[14:0]}))
    else $error("first mask basis word is wrong");
  second_mask_a: assert property ((info == 10'h080) |-> (plain_code == 30'h00e6edc7))
    else $error("second mask basis word is wrong");
  all_ones_a: assert property ((info == 10'h020) |-> (plain_code == 30'h3fffffff))
    else $error("all-ones basis word is wrong");
  ovsf_one_a: assert property ((info == 10'h001) |-> (plain_code == 30'h2aaad555))
    else $error("index one basis word is wrong");
  split_comp_a: assert property ((word_a == 5'h01) |-> (split_code_a == 15'h7fff))
    else $error("complemented code zero is wrong");
  split_top_a: assert property ((word_b == 5'h1f) |-> (split_code_b == 15'h1669))
    else $error("complemented code fifteen is wrong");

endmodule

`default_nettype wire

/* File: hw/tfci_block_encoder.sv */
// Purpose: Indicator encoder; pads, encodes, punctures and streams code bits by slot.
// Assumes: Configuration holds from start through the load cycle; out_ready may stall.
// Notes: One code bit per accepted handshake; a frame ends with last on its final bit.
//
// Functional notes
// - Indicators shorter than ten bits get their upper bits forced to zero.
// - Normal mode gives a 30-bit word, two bits per slot.
// - The 32-chip word sums all-ones, five OVSF codes and four masks.
// - Masks two to four are fixed 32-chip constants as listed.
// - Mask one is a fixed constant, resolved from its printed form to 32 chips.
// - Chips one and seventeen are deleted, leaving 30 bits.
// - Remaining bits are indexed 0 to 29, index 29 most significant.
// - Downlink with spreading factor under 128 sends each bit four times.
// - Split mode uses a biorthogonal length-16 code of OVSF codes and complements.
// - Upper four bits pick the code index; a set low bit complements it.
// - Split code words drop their first chip; index 14 is most significant.
// - Split mode encodes two independent five-bit words into two 15-bit words.
// - Within a slot the more significant bit goes first.
// - With repetition slot n sends bit 29-2n four times, then 28-2n four times.

`timescale 1ns/1ps
`default_nettype none

module tfci_block_encoder
  import tfci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [9:0] indicator,
  input wire logic [4:0] split_word_a,
  input wire logic [4:0] split_word_b,
  input wire tfci_cfg_t cfg,
  input wire logic out_ready,
  output logic busy,
  output logic out_valid,
  output tfci_sym_t out_sym
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [9:0] pad_info(input logic [9:0] value, input logic [3:0] len);
    logic [9:0] p;
    p = '0;
    for (int i = 0; i < INFO_BITS; i++) begin
      p[i] = value[i] & (4'(i) < len);
    end
    return p;
  endfunction

  // Picks the bit sent at a slot and half-slot position.
  function automatic logic pick_bit(
    input logic split,
    input logic [3:0] slot,
    input logic half,
    input logic [29:0] plain,
    input logic [14:0] code_a,
    input logic [14:0] code_b
  );
    logic [4:0] idx;
    logic [3:0] sidx;
    idx = TOP_BIT_IDX - {slot, 1'b0} - {4'h0, half};
    sidx = SPLIT_TOP_IDX - slot;
    if (split) begin
      return half ? code_b[sidx] : code_a[sidx];
    end
    return plain[idx];
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  enc_regs_t cur_ff;
  enc_regs_t nxt_regs;
  logic [29:0] plain_code;
  logic [14:0] split_code_a;
  logic [14:0] split_code_b;
  logic last_bit;
  logic accept;

  tfci_code_core u_core (
    .clk(clk),
    .rst_n(rst_n),
    .info(cur_ff.info),
    .word_a(cur_ff.word_a),
    .word_b(cur_ff.word_b),
    .plain_code(plain_code),
    .split_code_a(split_code_a),
    .split_code_b(split_code_b)
  );

  assign last_bit = (cur_ff.slot == LAST_SLOT) && cur_ff.half &&
                    (!cur_ff.rep || (cur_ff.rep_cnt == LAST_REP));
  assign accept = (cur_ff.state == ST_SEND) && out_ready;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_regs = cur_ff;
    case (cur_ff.state)
      ST_IDLE: begin
        if (start) begin
          // The length is taken once per frame; the controller keeps it per call.
          nxt_regs.info = pad_info(indicator, cfg.indicator_len);
          nxt_regs.word_a = split_word_a;
          nxt_regs.word_b = split_word_b;
          nxt_regs.split = cfg.split_mode;
          nxt_regs.rep = cfg.downlink && (cfg.spreading_factor < SF_REP_LIMIT);
          nxt_regs.slot = '0;
          nxt_regs.half = 1'b0;
          nxt_regs.rep_cnt = '0;
          nxt_regs.state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // Waits one cycle so the code core sees the latched words.
        nxt_regs.out_bit = pick_bit(cur_ff.split, cur_ff.slot, cur_ff.half,
                                    plain_code, split_code_a, split_code_b);
        nxt_regs.state = ST_SEND;
      end
      ST_SEND: begin
        if (out_ready) begin
          if (last_bit) begin
            nxt_regs.state = ST_IDLE;
          end else begin
            if (cur_ff.rep && (cur_ff.rep_cnt != LAST_REP)) begin
              nxt_regs.rep_cnt = cur_ff.rep_cnt + 2'h1;
            end else begin
              nxt_regs.rep_cnt = '0;
              nxt_regs.half = ~cur_ff.half;
              if (cur_ff.half) begin
                nxt_regs.slot = cur_ff.slot + 4'h1;
              end
            end
            nxt_regs.out_bit = pick_bit(cur_ff.split, nxt_regs.slot, nxt_regs.half,
                                        plain_code, split_code_a, split_code_b);
          end
        end
      end
      default: begin
        nxt_regs = ENC_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= ENC_RESET;
    end else begin
      cur_ff <= nxt_regs;
    end
  end

  assign busy = (cur_ff.state != ST_IDLE);
  assign out_valid = (cur_ff.state == ST_SEND);
  assign out_sym.code_bit = cur_ff.out_bit;
  assign out_sym.slot = cur_ff.slot;
  assign out_sym.last = out_valid && last_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers: bits accepted in the current frame.

  logic [6:0] sent_cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sent_cnt_ff <= '0;
    end else if (cur_ff.state == ST_LOAD) begin
      sent_cnt_ff <= '0;
    end else if (accept) begin
      sent_cnt_ff <= sent_cnt_ff + 7'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  pad_upper_a: assert property ((cur_ff.state == ST_LOAD) |->
      ((cur_ff.info >> cfg.indicator_len) == 10'h000))
    else $error("unused upper indicator bits are not zero");
  plain_frame_a: assert property ((accept && last_bit && !cur_ff.rep) |->
      (sent_cnt_ff == FRAME_BITS_PLAIN - 7'h01))
    else $error("plain frame does not carry thirty bits");
  rep_frame_a: assert property ((accept && last_bit && cur_ff.rep) |->
      (sent_cnt_ff == FRAME_BITS_REP - 7'h01))
    else $error("repeated frame does not carry one hundred twenty bits");
  rep_hold_a: assert property ((accept && cur_ff.rep && (cur_ff.rep_cnt != LAST_REP)) |=>
      (out_sym.code_bit == $past(out_sym.code_bit)))
    else $error("repeated bit changed inside its group of four");
  slot_first_a: assert property ((out_valid && !cur_ff.split && !cur_ff.half) |->
      (out_sym.code_bit == plain_code[TOP_BIT_IDX - {cur_ff.slot, 1'b0}]))
    else $error("slot does not open with its more significant bit");
  split_pair_a: assert property ((out_valid && cur_ff.split && cur_ff.half) |->
      (out_sym.code_bit == split_code_b[SPLIT_TOP_IDX - cur_ff.slot]))
    else $error("second split word bit is misplaced");
  load_send_a: assert property (((cur_ff.state == ST_IDLE) && start) |=>
      (cur_ff.state == ST_LOAD) ##1 out_valid)
    else $error("start did not lead to a frame two cycles later");
  stall_keep_a: assert property ((out_valid && !out_ready) |=>
      (out_valid && $stable(out_sym)))
    else $error("output changed while stalled");

endmodule

`default_nettype wire

/* File: sim/slot_sink.sv */
// Purpose: Slot-mapper model that takes code bits from the encoder.
// Assumes: One clock; ready changes only just after a rising edge.
// Notes: Random stalls make the encoder hold an offered bit for several cycles.

`timescale 1ns/1ps
`default_nettype none

module slot_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall_en,
  output logic out_ready
);
  // Roughly one cycle in three is refused while stalling is enabled.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= stall_en ? (($urandom % 3) != 0) : 1'b1;
    end
  end
endmodule

`default_nettype wire

/* File: sim/tfci_block_encoder_tb_top.sv */
// Purpose: Self-checking bench for the indicator encoder.
// Assumes: Expected code bits are built here from the code definitions.
// Notes: The driver queues each expected bit; a monitor pops one per accepted bit.

`timescale 1ns/1ps
`default_nettype none

module tfci_block_encoder_tb_top;
  import tfci_pkg::*;
  logic clk, rst_n, start, out_ready, busy, out_valid, stall_en;
  logic [9:0] indicator;
  logic [4:0] split_word_a, split_word_b;
  tfci_cfg_t cfg;
  tfci_sym_t out_sym;
  tfci_sym_t exp_q[$];
  int fails = 0;
  int num_checks = 0;

  tfci_block_encoder tfci_block_encoder_i (.clk(clk), .rst_n(rst_n), .start(start),
    .indicator(indicator), .split_word_a(split_word_a), .split_word_b(split_word_b),
    .cfg(cfg), .out_ready(out_ready), .busy(busy), .out_valid(out_valid), .out_sym(out_sym));
  slot_sink slot_sink_i (.clk(clk), .rst_n(rst_n), .stall_en(stall_en), .out_ready(out_ready));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [29:0] rm_code(input logic [9:0] a);
    logic [29:0] b;
    logic ch;
    int k;
    k = 29;
    for (int c = 0; c < 32; c++) begin
      ch = a[5];
      for (int i = 0; i < 5; i++) ch = ch ^ (a[i] & c[i]);
      ch = ch ^ (a[6] & FIRST_MASK_SEQUENCE[31-c]) ^ (a[7] & SECOND_MASK_SEQUENCE[31-c])
        ^ (a[8] & THIRD_MASK_SEQUENCE[31-c]) ^ (a[9] & FOURTH_MASK_SEQUENCE[31-c]);
      if (c != 0 && c != 16) begin
        b[k] = ch;
        k--;
      end
    end
    return b;
  endfunction

  function automatic logic [14:0] bio_code(input logic [4:0] w);
    logic [14:0] b;
    for (int c = 1; c < 16; c++) b[15-c] = (^(w[4:1] & 4'(c))) ^ w[0];
    return b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  task automatic run_frame(input tfci_cfg_t cf, input logic [9:0] ind, input logic [4:0] wa,
                           input logic [4:0] wb);
    logic [29:0] code;
    logic [14:0] ca, cb;
    logic [9:0] info;
    tfci_sym_t s;
    int reps, n;
    info = ind;
    for (int i = 0; i < 10; i++) if (i >= cf.indicator_len) info[i] = 1'b0;
    code = rm_code(info);
    ca = bio_code(wa);
    cb = bio_code(wb);
    reps = (cf.downlink && cf.spreading_factor < 10'd128) ? 4 : 1;
    for (int sl = 0; sl < 15; sl++) begin
      for (int h = 0; h < 2; h++) begin
        for (int r = 0; r < reps; r++) begin
          s.code_bit = cf.split_mode ? (h ? cb[14-sl] : ca[14-sl]) : code[29-2*sl-h];
          s.slot = 4'(sl);
          s.last = (sl == 14 && h == 1 && r == reps - 1);
          exp_q.push_back(s);
        end
      end
    end
    @(posedge clk);
    start <= 1'b1;
    cfg <= cf;
    indicator <= ind;
    split_word_a <= wa;
    split_word_b <= wb;
    @(posedge clk);
    start <= 1'b0;
    repeat (4) @(posedge clk);
    // A start and a new setting in mid-frame must leave the frame untouched.
    start <= 1'b1;
    indicator <= ~ind;
    split_word_a <= ~wa;
    cfg.downlink <= ~cf.downlink;
    cfg.spreading_factor <= 10'h3ff - cf.spreading_factor;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (n < 1000) begin
      @(posedge clk);
      if (busy === 1'b0) break;
      n++;
    end
    check("idle", 32'h0, {31'h0, busy});
    check("left", 32'h0, exp_q.size());
  endtask

  always @(posedge clk) begin
    if (rst_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) check("extra", 32'h0, 32'h1);
      else check("sym", 32'(exp_q.pop_front()), 32'(out_sym));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    tfci_cfg_t cf;
    logic [4:0] wlist[4];
    logic [9:0] sfs[4];
    logic [9:0] dlist[4];
    rst_n = 1'b0;
    start = 1'b0;
    indicator = 10'h000;
    split_word_a = 5'h00;
    split_word_b = 5'h00;
    cfg = '0;
    stall_en = 1'b0;
    wlist = '{5'h00, 5'h01, 5'h1f, 5'h0a};
    sfs = '{10'h07f, 10'h080, 10'h004, 10'h200};
    dlist = '{10'h040, 10'h080, 10'h020, 10'h001};
    void'($urandom(77));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      // Split mode only ever runs on a downlink with a shared channel.
      cf = '{split_mode: 1'b1, downlink: 1'b1, spreading_factor: (i < 4) ? 10'h100 : 10'h040,
             indicator_len: 4'ha};
      stall_en <= i[0];
      run_frame(cf, 10'($urandom), wlist[i%4], wlist[3-(i%4)]);
    end
    for (int len = 0; len < 12; len++) begin
      cf = '{split_mode: 1'b0, downlink: len[1] | len[0], spreading_factor: sfs[len%4],
             indicator_len: (len == 11) ? 4'hf : 4'(len)};
      stall_en <= len[1];
      run_frame(cf, 10'($urandom), 5'($urandom), 5'($urandom));
    end
    // Single basis words, so mask one, mask two, all-ones and OVSF index one are each seen on their own.
    for (int d = 0; d < 4; d++) begin
      cf = '{split_mode: 1'b0, downlink: 1'b0, spreading_factor: 10'h100,
             indicator_len: 4'ha};
      run_frame(cf, dlist[d], 5'($urandom), 5'($urandom));
    end
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule

`default_nettype wire
